// ---- verilog/icc_params.svh ----
// Constants of the instruction cycle control core
// Function
// [RULE_01] Each machine cycle is exactly four system clocks.
// [RULE_02] Most instructions take one machine cycle; jump, call, return and table read take two.
// [RULE_03] A write to the program counter low byte acts as a jump and costs one extra cycle.
// [RULE_04] A skip takes one cycle when not taken and one more when taken.
// [RULE_05] Addition sets carry above 255; subtraction sets it on a borrow below zero.
// [RULE_06] Increment and decrement change the operand by one, into memory or accumulator.
// [RULE_07] AND, OR, XOR and complement set the zero flag on a zero result.
// [RULE_08] Rotates move one bit; the carry forms swap the outgoing bit with carry.
// [RULE_09] A call saves the next address and a return resumes there.
// [RULE_10] A jump loads its target without saving a return address.
// [RULE_11] Conditional branches test a byte or a bit and then skip or not.
// [RULE_12] Moves go memory to accumulator, accumulator to memory, immediate to accumulator.
// [RULE_13] ALU work takes the accumulator as one operand; result to accumulator or memory.
// [RULE_14] Both watchdog clears back to back clear timeout and power-down; one alone does not.
// [RULE_15] An extra cycle drops the fetched word and idles before fetching the new address.
`ifndef ICC_PARAMS_SVH
`define ICC_PARAMS_SVH
// Machine cycle phases
`define ICC_PHASE_FIRST 2'h0
`define ICC_PHASE_FETCH 2'h1
`define ICC_PHASE_READ 2'h2
`define ICC_PHASE_LAST 2'h3
// Program counter and stack
`define ICC_RESET_PC 12'h000
`define ICC_PC_STEP 12'h001
`define ICC_SKIP_STEP 12'h002
`define ICC_PC_LOW_ADDR 8'h06
`define ICC_SP_TOP 3'h5
`define ICC_SP_ZERO 3'h0
`define ICC_SP_ONE 3'h1
`define ICC_ONE 8'h01
`define ICC_ZERO 8'h00
// Instruction fields
`define ICC_OP_RANGE 15:12
`define ICC_SUB_RANGE 11:8
`define ICC_ADDR_RANGE 11:0
`define ICC_OPND_RANGE 7:0
`define ICC_BIT_RANGE 10:8
`define ICC_TBL_HI_RANGE 15:8
// Opcodes
`define ICC_OP_NOP 4'h0
`define ICC_OP_ALU_A 4'h1
`define ICC_OP_ALU_M 4'h2
`define ICC_OP_ALU_X 4'h3
`define ICC_OP_SKIP 4'h4
`define ICC_OP_SKIP_SET 4'h5
`define ICC_OP_SKIP_CLR 4'h6
`define ICC_OP_JUMP 4'h8
`define ICC_OP_CALL 4'h9
`define ICC_OP_RETURN 4'hA
`define ICC_OP_TABLE 4'hB
`define ICC_OP_WDT 4'hC
// Skip and watchdog sub codes
`define ICC_SK_SZ 4'h0
`define ICC_SK_SZA 4'h1
`define ICC_SK_SIZ 4'h2
`define ICC_SK_SDZ 4'h3
`define ICC_SK_SIZA 4'h4
`define ICC_SK_SDZA 4'h5
`define ICC_WDT_FIRST 4'h1
`define ICC_WDT_SECOND 4'h2
// ALU functions
`define ICC_FN_ADD 4'h0
`define ICC_FN_ADC 4'h1
`define ICC_FN_SUB 4'h2
`define ICC_FN_SBC 4'h3
`define ICC_FN_AND 4'h4
`define ICC_FN_OR 4'h5
`define ICC_FN_XOR 4'h6
`define ICC_FN_INVERT 4'h7
`define ICC_FN_INC 4'h8
`define ICC_FN_DECR 4'h9
`define ICC_FN_ROTR 4'hA
`define ICC_FN_ROTL 4'hB
`define ICC_FN_ROTRC 4'hC
`define ICC_FN_ROTLC 4'hD
`define ICC_FN_MOVM 4'hE
`define ICC_FN_MOVA 4'hF
`endif

// ---- verilog/icc_pkg.sv ----
// Types shared by the instruction cycle control core
package icc_pkg;
	typedef enum logic [1:0] {ICC_ST_EXEC = 2'b01, ICC_ST_IDLE = 2'b10} icc_state_e;
	typedef logic [11:0] icc_pc_t;
	typedef logic [7:0] icc_byte_t;
endpackage

// ---- verilog/icc_alu.sv ----
// Byte ALU of the instruction cycle control core
`timescale 1ns/10ps
`include "icc_params.svh"
module icc_alu
	import icc_pkg::*;
(
	// Operands
	input wire logic [3:0] func,
	input wire icc_byte_t accIn,
	input wire icc_byte_t opIn,
	input wire logic carryIn,
	// Results
	output icc_byte_t result,
	output logic carryOut,
	output logic carryUpd,
	output logic zeroOut,
	output logic zeroUpd
);
	logic cin;
	logic [8:0] sumW;
	logic [8:0] difW;

	// Carry in only for the with-carry forms
	assign cin = (func == `ICC_FN_ADC || func == `ICC_FN_SBC) ? carryIn : 1'b0;
	assign sumW = {1'b0, accIn} + {1'b0, opIn} + {8'h00, cin};
	// Bit 8 of the difference is the borrow
	assign difW = {1'b0, accIn} - {1'b0, opIn} - {8'h00, cin};

	// Function select; accumulator is the first operand of the two-operand functions
	always_comb
	begin
		result = opIn;
		carryOut = carryIn;
		carryUpd = 1'b0;
		zeroUpd = 1'b1;
		case (func)
			`ICC_FN_ADD, `ICC_FN_ADC:
			begin
				result = sumW[7:0]; // [RULE_13]
				carryOut = sumW[8]; // [RULE_05]
				carryUpd = 1'b1;
			end
			`ICC_FN_SUB, `ICC_FN_SBC:
			begin
				result = difW[7:0];
				carryOut = difW[8]; // [RULE_05]
				carryUpd = 1'b1;
			end
			`ICC_FN_AND: result = accIn & opIn; // [RULE_07]
			`ICC_FN_OR: result = accIn | opIn;
			`ICC_FN_XOR: result = accIn ^ opIn;
			`ICC_FN_INVERT: result = ~opIn;
			`ICC_FN_INC: result = opIn + `ICC_ONE; // [RULE_06]
			`ICC_FN_DECR: result = opIn - `ICC_ONE;
			`ICC_FN_ROTR, `ICC_FN_ROTL:
			begin
				result = (func == `ICC_FN_ROTR) ? {opIn[0], opIn[7:1]}
					: {opIn[6:0], opIn[7]}; // [RULE_08]
				zeroUpd = 1'b0;
			end
			`ICC_FN_ROTRC:
			begin
				result = {carryIn, opIn[7:1]}; // [RULE_08]
				carryOut = opIn[0];
				carryUpd = 1'b1;
				zeroUpd = 1'b0;
			end
			`ICC_FN_ROTLC:
			begin
				result = {opIn[6:0], carryIn};
				carryOut = opIn[7];
				carryUpd = 1'b1;
				zeroUpd = 1'b0;
			end
			`ICC_FN_MOVA:
			begin
				result = accIn; // [RULE_12]
				zeroUpd = 1'b0;
			end
			default: zeroUpd = 1'b0; // Plain move of the operand
		endcase
	end

	assign zeroOut = (result == `ICC_ZERO);
endmodule

// ---- verilog/icc_core.sv ----
// Instruction sequencer and execute stage of the small 8-bit core
`timescale 1ns/10ps
`include "icc_params.svh"
module icc_core
	import icc_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Program memory
	output icc_pc_t progAddr,
	input wire logic [15:0] progData,
	// Data memory
	output icc_byte_t dataAddr,
	input wire icc_byte_t dataRdData,
	output icc_byte_t dataWrData,
	output logic dataWrEn,
	// Watchdog and halt events
	input wire logic wdtTimeoutEvent,
	input wire logic powerdownEvent,
	// Visible state
	output icc_byte_t accumulator,
	output logic carryFlag,
	output logic zeroFlag,
	output logic timeoutFlag,
	output logic powerdownFlag,
	output icc_byte_t tableHigh,
	output logic cycleStart,
	output logic extraCycle
);
	icc_state_e stateReg;
	logic [1:0] phaseReg;
	logic [15:0] instrReg;
	logic [15:0] tableWordReg;
	icc_byte_t memReg;
	icc_pc_t pcReg;
	icc_pc_t pcNext;
	icc_pc_t stackMem [0:5];
	logic [2:0] spReg;
	logic [1:0] lastClearReg;
	logic commit;
	logic lastPhase;
	logic [3:0] opc;
	logic [3:0] sub;
	logic [3:0] aluFunc;
	icc_byte_t aluOperand;
	icc_byte_t aluResult;
	logic aluCarry;
	logic aluCarryUpd;
	logic aluZero;
	logic aluZeroUpd;
	logic isAluOp;
	logic isSkipByte;
	logic isSkipBit;
	logic skipTaken;
	logic pcLowWrite;
	logic accWrite;
	logic memWrite;
	logic needExtra;
	logic wdtFirst;
	logic wdtSecond;
	logic clearPair;
	logic [8:0] sumCheck;
	icc_byte_t incCheck;

	// Wrapping stack pointer step, used for push and pop
	function automatic logic [2:0] spStep(input logic [2:0] sp, input logic up);
		logic [2:0] r;
		r = sp;
		if (up)
			r = (sp == `ICC_SP_TOP) ? `ICC_SP_ZERO : sp + `ICC_SP_ONE;
		else
			r = (sp == `ICC_SP_ZERO) ? `ICC_SP_TOP : sp - `ICC_SP_ONE;
		return r;
	endfunction

	// ****************************************
	// Machine cycle timing
	// ****************************************

	// Free running phase counter, four clocks per machine cycle
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			phaseReg <= `ICC_PHASE_FIRST;
		else
			phaseReg <= phaseReg + 2'h1; // [RULE_01]
	end

	assign lastPhase = (phaseReg == `ICC_PHASE_LAST);
	assign commit = lastPhase && (stateReg == ICC_ST_EXEC);

	// Cycle start marker, high during phase zero
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			cycleStart <= 1'b0;
		else
			cycleStart <= lastPhase;
	end

	// ****************************************
	// Decode
	// ****************************************

	assign opc = instrReg[`ICC_OP_RANGE];
	assign sub = instrReg[`ICC_SUB_RANGE];
	assign isAluOp = (opc == `ICC_OP_ALU_A) || (opc == `ICC_OP_ALU_M)
		|| (opc == `ICC_OP_ALU_X);
	assign isSkipByte = (opc == `ICC_OP_SKIP);
	assign isSkipBit = (opc == `ICC_OP_SKIP_SET) || (opc == `ICC_OP_SKIP_CLR);
	assign wdtFirst = (opc == `ICC_OP_WDT) && (sub == `ICC_WDT_FIRST);
	assign wdtSecond = (opc == `ICC_OP_WDT) && (sub == `ICC_WDT_SECOND);

	// Skip forms borrow the increment and decrement paths
	always_comb
	begin
		aluFunc = `ICC_FN_MOVM;
		if (isAluOp)
			aluFunc = sub;
		else if (isSkipByte)
		begin
			case (sub)
				`ICC_SK_SIZ, `ICC_SK_SIZA: aluFunc = `ICC_FN_INC;
				`ICC_SK_SDZ, `ICC_SK_SDZA: aluFunc = `ICC_FN_DECR;
				default: aluFunc = `ICC_FN_MOVM;
			endcase
		end
	end

	// Immediate forms take the operand from the word itself
	assign aluOperand = (opc == `ICC_OP_ALU_X)
		? instrReg[`ICC_OPND_RANGE] : memReg; // [RULE_12]

	icc_alu u_alu (
		.func(aluFunc),
		.accIn(accumulator),
		.opIn(aluOperand),
		.carryIn(carryFlag),
		.result(aluResult),
		.carryOut(aluCarry),
		.carryUpd(aluCarryUpd),
		.zeroOut(aluZero),
		.zeroUpd(aluZeroUpd)
	);

	// Destinations and branch decisions
	always_comb
	begin
		skipTaken = 1'b0;
		if (isSkipByte)
			skipTaken = aluZero; // [RULE_11]
		else if (opc == `ICC_OP_SKIP_SET)
			skipTaken = memReg[instrReg[`ICC_BIT_RANGE]];
		else if (opc == `ICC_OP_SKIP_CLR)
			skipTaken = !memReg[instrReg[`ICC_BIT_RANGE]];
	end

	// Memory-destination writes to the low PC byte redirect the PC
	assign pcLowWrite = (opc == `ICC_OP_ALU_M)
		&& (instrReg[`ICC_OPND_RANGE] == `ICC_PC_LOW_ADDR); // [RULE_03]
	assign accWrite = ((opc == `ICC_OP_ALU_A) || (opc == `ICC_OP_ALU_X))
		&& (sub != `ICC_FN_MOVA) || (isSkipByte && (sub == `ICC_SK_SZA
		|| sub == `ICC_SK_SIZA || sub == `ICC_SK_SDZA)); // [RULE_13]
	assign memWrite = ((opc == `ICC_OP_ALU_M) && !pcLowWrite) || (isSkipByte
		&& (sub == `ICC_SK_SIZ || sub == `ICC_SK_SDZ)); // [RULE_06]
	assign needExtra = (opc == `ICC_OP_JUMP) || (opc == `ICC_OP_CALL)
		|| (opc == `ICC_OP_RETURN) || (opc == `ICC_OP_TABLE)
		|| pcLowWrite || skipTaken; // [RULE_02] [RULE_04]

	// Next program counter
	always_comb
	begin
		pcNext = pcReg + `ICC_PC_STEP;
		case (opc)
			`ICC_OP_JUMP, `ICC_OP_CALL:
				pcNext = instrReg[`ICC_ADDR_RANGE]; // [RULE_10]
			`ICC_OP_RETURN:
				pcNext = stackMem[spStep(spReg, 1'b0)]; // [RULE_09]
			default:
			begin
				if (pcLowWrite)
					pcNext = {pcReg[11:8], aluResult};
				else if (skipTaken)
					pcNext = pcReg + `ICC_SKIP_STEP; // [RULE_11]
			end
		endcase
	end

	// ****************************************
	// Sequencing
	// ****************************************

	// Extra cycles idle for one full machine cycle
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			stateReg <= ICC_ST_EXEC;
		else if (commit && needExtra)
			stateReg <= ICC_ST_IDLE; // [RULE_15]
		else if (lastPhase)
			stateReg <= ICC_ST_EXEC;
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			extraCycle <= 1'b0;
		else if (lastPhase)
			extraCycle <= commit && needExtra;
	end

	// Fetch only in execute cycles; idle cycles drop the word
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			instrReg <= {`ICC_OP_NOP, 12'h000};
		else if (stateReg == ICC_ST_EXEC && phaseReg == `ICC_PHASE_FETCH)
			instrReg <= progData; // [RULE_15]
	end

	// Table word is fetched during the idle cycle of a table read
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			tableWordReg <= 16'h0000;
		else if (stateReg == ICC_ST_IDLE && phaseReg == `ICC_PHASE_FETCH)
			tableWordReg <= progData; // [RULE_02]
	end

	// Data address follows the fetched word
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			dataAddr <= `ICC_ZERO;
		else if (stateReg == ICC_ST_EXEC && phaseReg == `ICC_PHASE_FETCH)
			dataAddr <= progData[`ICC_OPND_RANGE];
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			memReg <= `ICC_ZERO;
		else if (stateReg == ICC_ST_EXEC && phaseReg == `ICC_PHASE_READ)
			memReg <= dataRdData;
	end

	// PC and fetch address; table read points at {page, acc}
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			pcReg <= `ICC_RESET_PC;
			progAddr <= `ICC_RESET_PC;
		end
		else if (commit)
		begin
			pcReg <= pcNext;
			progAddr <= (opc == `ICC_OP_TABLE)
				? {pcReg[11:8], accumulator} : pcNext;
		end
		else if (lastPhase)
			progAddr <= pcReg;
	end

	// Return stack, wraps after six levels
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			spReg <= `ICC_SP_ZERO;
		else if (commit && opc == `ICC_OP_CALL)
		begin
			stackMem[spReg] <= pcReg + `ICC_PC_STEP; // [RULE_09]
			spReg <= spStep(spReg, 1'b1);
		end
		else if (commit && opc == `ICC_OP_RETURN)
			spReg <= spStep(spReg, 1'b0);
	end

	// ****************************************
	// Results
	// ****************************************

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			accumulator <= `ICC_ZERO;
		else if (commit && accWrite)
			accumulator <= aluResult; // [RULE_13]
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			carryFlag <= 1'b0;
			zeroFlag <= 1'b0;
		end
		else if (commit && isAluOp)
		begin
			if (aluCarryUpd)
				carryFlag <= aluCarry; // [RULE_05] [RULE_08]
			if (aluZeroUpd)
				zeroFlag <= aluZero; // [RULE_07]
		end
	end

	// Write strobe lasts one clock, in phase zero
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			dataWrEn <= 1'b0;
			dataWrData <= `ICC_ZERO;
			tableHigh <= `ICC_ZERO;
		end
		else if (commit && memWrite)
		begin
			dataWrEn <= 1'b1;
			dataWrData <= aluResult; // [RULE_13]
		end
		else if (lastPhase && stateReg == ICC_ST_IDLE && opc == `ICC_OP_TABLE)
		begin
			dataWrEn <= 1'b1;
			dataWrData <= tableWordReg[`ICC_OPND_RANGE];
			tableHigh <= tableWordReg[`ICC_TBL_HI_RANGE];
		end
		else
			dataWrEn <= 1'b0;
	end

	// ****************************************
	// Watchdog clear pairing
	// ****************************************

	assign clearPair = (wdtFirst && lastClearReg == 2'b10)
		|| (wdtSecond && lastClearReg == 2'b01);

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			lastClearReg <= 2'b00;
		else if (commit)
			lastClearReg <= {wdtSecond, wdtFirst};
	end

	// Hardware set wins over the instruction clear
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			timeoutFlag <= 1'b0;
			powerdownFlag <= 1'b0;
		end
		else
		begin
			if (wdtTimeoutEvent)
				timeoutFlag <= 1'b1;
			else if (commit && clearPair)
				timeoutFlag <= 1'b0; // [RULE_14]
			if (powerdownEvent)
				powerdownFlag <= 1'b1;
			else if (commit && clearPair)
				powerdownFlag <= 1'b0;
		end
	end

	// ****************************************
	// Checks
	// ****************************************

	assign sumCheck = {1'b0, accumulator} + {1'b0, aluOperand};
	assign incCheck = memReg + `ICC_ONE;

	a_cycle_spacing: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE_01]
		cycleStart |=> !cycleStart [*3] ##1 cycleStart)
		else $error("machine cycle not four clocks");
	a_jump_two: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE_02]
		commit && opc == `ICC_OP_JUMP |=> (stateReg == ICC_ST_IDLE) [*4]
		##1 stateReg == ICC_ST_EXEC)
		else $error("jump did not take two cycles");
	a_pc_low_extra: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE_03]
		commit && pcLowWrite |=> stateReg == ICC_ST_IDLE && $stable(spReg))
		else $error("low pc write not treated as jump");
	a_skip_single: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE_04]
		commit && (isSkipByte || isSkipBit) && !skipTaken
		|=> stateReg == ICC_ST_EXEC && progAddr == $past(pcReg) + 12'h001)
		else $error("untaken skip not one cycle");
	a_add_carry: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE_05]
		commit && opc == `ICC_OP_ALU_X && sub == `ICC_FN_ADD
		|=> carryFlag == $past(sumCheck[8]))
		else $error("add carry wrong");
	a_inc_step: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE_06]
		commit && opc == `ICC_OP_ALU_A && sub == `ICC_FN_INC
		|=> accumulator == $past(incCheck))
		else $error("increment not by one");
	a_logic_zero: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE_07]
		commit && isAluOp && sub == `ICC_FN_XOR && aluResult == 8'h00
		|=> zeroFlag)
		else $error("zero flag missed");
	a_rotate_carry: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE_08]
		commit && opc == `ICC_OP_ALU_A && sub == `ICC_FN_ROTRC
		|=> carryFlag == $past(memReg[0]) && accumulator[7] == $past(carryFlag))
		else $error("rotate through carry wrong");
	a_jump_target: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE_10]
		commit && opc == `ICC_OP_JUMP
		|=> pcReg == $past(instrReg[11:0]) && $stable(spReg))
		else $error("jump target wrong");
	a_wdt_single: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE_14]
		commit && wdtFirst && lastClearReg != 2'b10 && !wdtTimeoutEvent
		|=> timeoutFlag == $past(timeoutFlag))
		else $error("single watchdog clear changed flag");
	a_idle_discard: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE_15]
		stateReg == ICC_ST_IDLE && phaseReg == `ICC_PHASE_FETCH
		|=> $stable(instrReg))
		else $error("fetched word kept during idle cycle");
endmodule

// ---- tb/icc_mem_model.sv ----
// Program and data memory standing beside the core
`timescale 1ns/10ps
module icc_mem_model
	import icc_pkg::*;
(
	// Clock
	input wire logic core_clk,
	// Program memory
	input wire icc_pc_t progAddr,
	output logic [15:0] progData,
	// Data memory
	input wire icc_byte_t dataAddr,
	output icc_byte_t dataRdData,
	input wire icc_byte_t dataWrData,
	input wire logic dataWrEn
);
	logic [15:0] prog [0:4095];
	icc_byte_t dmem [0:255];

	// Registered program read, one clock of latency as the core allows
	always @(posedge core_clk)
	begin
		progData <= prog[progAddr];
	end

	// Read data follows the address at once
	assign dataRdData = dmem[dataAddr];

	// Plain always, the bench preloads the array before reset
	always @(posedge core_clk)
	begin
		if (dataWrEn)
			dmem[dataAddr] <= dataWrData;
	end
endmodule

// ---- tb/tb_top.sv ----
// Self-checking bench for the instruction cycle control core
`timescale 1ns/10ps
`include "icc_params.svh"
module tb_top
	import icc_pkg::*;
;
	localparam int END_PC = 12'h0F0;
	localparam int LIMIT = 20000;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic wdtTimeoutEvent = 1'b0;
	logic powerdownEvent = 1'b0;
	icc_pc_t progAddr;
	logic [15:0] progData;
	icc_byte_t dataAddr, dataRdData, dataWrData, accumulator, tableHigh;
	logic dataWrEn, carryFlag, zeroFlag, timeoutFlag, powerdownFlag;
	logic cycleStart, extraCycle;
	int err_count = 0;
	int total_checks = 0;
	logic [31:0] lfsr = 32'h0001583A;
	logic [15:0] img [0:4095];
	int dm [0:255];
	int stk [$];
	int acc, cf, zf, tf, pf, th, pc, prevWdt, wrWhen, wa, wd, gap, cycles;
	bit extra, started, idleNow, done;

	// 250 MHz system clock
	always #2 core_clk = ~core_clk;

	icc_core DUT (.core_clk, .rst_n, .progAddr, .progData, .dataAddr,
		.dataRdData, .dataWrData, .dataWrEn, .wdtTimeoutEvent,
		.powerdownEvent, .accumulator, .carryFlag, .zeroFlag, .timeoutFlag,
		.powerdownFlag, .tableHigh, .cycleStart, .extraCycle);

	icc_mem_model mem (.core_clk, .progAddr, .progData, .dataAddr,
		.dataRdData, .dataWrData, .dataWrEn);

	// ****************************************
	// Reference model
	// ****************************************

	// Fixed-seed shift register feeds every random choice
	function automatic logic [31:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction

	task automatic chk(input logic [15:0] got, input int exp, input string s);
		total_checks++;
		if (got !== 16'(exp))
		begin
			err_count++;
			$display("MISMATCH %0t: %s got %h want %h", $time, s, got, exp);
		end
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Byte ALU, flags kept only where the core keeps them
	task automatic alu(input int fn, input int m, output int r);
		int s;
		case (fn)
			0: s = acc + m;
			1: s = acc + m + cf;
			2: s = acc - m;
			3: s = acc - m - cf;
			4: s = acc & m;
			5: s = acc | m;
			6: s = acc ^ m;
			7: s = ~m;
			8: s = m + 1;
			9: s = m - 1;
			10: s = (m >> 1) | ((m & 1) << 7);
			11: s = (m << 1) | (m >> 7);
			12: s = (m >> 1) | (cf << 7);
			13: s = (m << 1) | cf;
			14: s = m;
			default: s = acc;
		endcase
		if (fn < 4)
			cf = (s > 255 || s < 0);
		if (fn == 12)
			cf = m & 1;
		if (fn == 13)
			cf = (m >> 7) & 1;
		r = s & 255;
		if (fn < 10)
			zf = (r == 0);
	endtask

	task automatic mem_wr(input int a, input int r);
		dm[a] = r & 255;
		wa = a;
		wd = r & 255;
		wrWhen = 1;
	endtask

	// One instruction; sets whether an idle cycle follows
	task automatic iss_step();
		logic [15:0] w;
		int op, sb, a, m, r, npc;
		bit skip;
		w = img[pc];
		op = w[15:12];
		sb = w[11:8];
		a = w[7:0];
		m = dm[a];
		npc = pc + 1;
		skip = 0;
		extra = op >= 8 && op <= 11;
		wrWhen = 0;
		case (op)
			1, 2, 3:
			begin
				alu(sb, op == 3 ? a : m, r);
				if (op != 2)
					acc = r;
				else if (a == `ICC_PC_LOW_ADDR)
				begin
					npc = (pc & 12'hF00) | r;
					extra = 1;
				end
				else
					mem_wr(a, r);
			end
			4:
			begin
				r = (sb == 2 || sb == 4) ? m + 1 : (sb == 3 || sb == 5) ? m - 1 : m;
				r = r & 255;
				if (sb == 1 || sb > 3)
					acc = r;
				else if (sb > 1)
					mem_wr(a, r);
				skip = (r == 0);
			end
			5: skip = ((m >> sb) & 1) == 1;
			6: skip = ((m >> sb) & 1) == 0;
			8: npc = w[11:0];
			9:
			begin
				stk.push_back(pc + 1);
				npc = w[11:0];
			end
			10: npc = stk.pop_back();
			11:
			begin
				r = img[(pc & 12'hF00) | acc];
				mem_wr(a, r);
				wrWhen = 2;
				th = r >> 8;
			end
			12:
			if (prevWdt + sb == 3)
			begin
				tf = 0;
				pf = 0;
			end
			default: ;
		endcase
		prevWdt = op == 12 ? sb : 0;
		if (skip)
		begin
			npc = pc + 2;
			extra = 1;
		end
		if (pc == END_PC)
			done = 1;
		pc = npc & 12'hFFF;
	endtask

	function automatic logic [15:0] gen(logic [31:0] r);
		logic [3:0] op, sb;
		op = r[2:0] == 3'h7 ? 4'hC : {1'b0, r[2:0]};
		sb = r[7:4];
		if (op == 4'h4)
			sb = sb % 4'h6;
		if (op == 4'h5 || op == 4'h6)
			sb[3] = 1'b0;
		if (op == 4'hC)
			sb = {3'h0, r[4]} + 4'h1;
		if (op == 4'h0)
			sb = 4'h0;
		return {op, sb, op == 4'h3 ? r[15:8] : {3'h1, r[12:8]}};
	endfunction

	// ****************************************
	// Stimulus and checks
	// ****************************************

	// Per-clock comparison against the model, events driven once per edge
	always @(posedge core_clk)
	begin
		logic [31:0] r;
		bit evT, evP;
		evT = 0;
		evP = 0;
		cycles++;
		if (cycles == LIMIT)
		begin
			err_count++; // A hang ends the run as a failure
			done = 1;
		end
		if (rst_n && cycleStart)
		begin
			if (started)
				chk(16'(gap), 4, "cycle length");
			gap = 1;
			started = 1;
			// The marker follows a commit; an idle cycle commits nothing
			if (idleNow)
				idleNow = 0;
			else
			begin
				iss_step();
				idleNow = extra;
			end
			chk(16'(extraCycle), idleNow, "idle cycle");
			chk(16'(dataWrEn), wrWhen == 1, "write strobe");
			if (wrWhen == 1)
			begin
				chk(16'(dataAddr), wa, "write address");
				chk(16'(dataWrData), wd, "write data");
			end
			if (wrWhen > 0)
				wrWhen--;
			// State settles only once the idle cycle has passed
			if (!idleNow)
			begin
				chk(16'(accumulator), acc, "accumulator");
				chk(16'(carryFlag), cf, "carry");
				chk(16'(zeroFlag), zf, "zero");
				chk(16'(timeoutFlag), tf, "timeout flag");
				chk(16'(powerdownFlag), pf, "powerdown flag");
				chk(16'(tableHigh), th, "table high");
				chk(16'(progAddr), pc, "fetch address");
			end
			// Events land in the next cycle, before its commit
			r = rnd();
			evT = pc < 2 || (pc > 12'h040 && r[2:0] == 3'h0);
			evP = pc < 2 || (pc > 12'h040 && r[5:3] == 3'h0);
			tf = tf | evT;
			pf = pf | evP;
		end
		else if (rst_n)
		begin
			gap++;
			chk(16'(extraCycle), idleNow, "idle level");
			chk(16'(dataWrEn), 0, "strobe width");
		end
		wdtTimeoutEvent <= evT;
		powerdownEvent <= evP;
	end

	// Directed head, random body, then the check of data memory against the model
	initial
	begin
		logic [31:0] r;
		logic [15:0] dir [0:15] = '{16'h3EFF, 16'h3001, 16'h3201, 16'h3300,
			16'hC100, 16'h36FE, 16'hC200, 16'h0000, 16'hC100, 16'hC200,
			16'h800C, 16'h3E55, 16'h9100, 16'h3E40, 16'h2F06, 16'h3E55};
		for (int i = 0; i < 4096; i++)
			img[i] = i < 16 ? dir[i] : 16'h0000;
		img[12'h040] = 16'hB030;
		img[12'h100] = 16'h3005;
		img[12'h101] = 16'hA000;
		for (int i = 12'h041; i < END_PC - 1; i++)
		begin
			r = rnd();
			img[i] = gen(r);
		end
		img[END_PC] = 16'h8000 | END_PC[15:0];
		for (int i = 0; i < 4096; i++)
			mem.prog[i] = img[i];
		for (int i = 0; i < 256; i++)
		begin
			r = rnd();
			dm[i] = int'(r[7:0]);
			mem.dmem[i] = r[7:0];
		end
		repeat (20) @(posedge core_clk);
		rst_n <= 1'b1;
		while (!done)
			@(posedge core_clk);
		repeat (8) @(posedge core_clk);
		for (int i = 0; i < 256; i++)
			chk(16'(mem.dmem[i]), dm[i], "data memory");
		results();
	end
endmodule
